// ==== logic/daq_board_io_register_interface.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "daq_regs.svh"

module daq_board_io_register_interface #(
    parameter logic [5:0] BASE_DEFAULT = `DAQ_DEFAULT_BASE
) (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [`DAQ_ADDR_BITS-1:0] i_addr,
    input wire logic i_io_read,
    input wire logic i_io_write,
    input wire logic [7:0] i_wdata,
    input wire logic [5:0] i_base,
    output logic [7:0] o_rdata,
    output logic o_rdata_valid,
    output logic o_timer_select,
    output logic [1:0] o_timer_addr,
    output logic o_timer_read,
    output logic o_timer_write,
    output logic [7:0] o_timer_wdata,
    input wire logic [7:0] i_timer_rdata,
    input wire logic [`DAQ_RESULT_BITS-1:0] i_conv_result,
    input wire logic i_conv_done,
    input wire logic i_pacer_tick,
    input wire logic i_external_trigger_input,
    input wire logic i_trigger_source_jumper,
    input wire logic i_input_configuration_jumper,
    input wire logic [15:0] i_digital_input,
    output logic o_conv_start,
    output logic o_irq,
    output logic o_dma_request,
    output logic [`DAQ_DAC_BITS-1:0] o_dac0,
    output logic [`DAQ_DAC_BITS-1:0] o_dac1,
    output logic [`DAQ_GAIN_BITS-1:0] o_gain_code,
    output logic [`DAQ_CHAN_BITS-1:0] o_channel,
    output logic [`DAQ_MODE_BITS-1:0] o_mode,
    output logic [15:0] o_digital_output
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic in_block(
        input logic [`DAQ_ADDR_BITS-1:0] addr,
        input logic [5:0] base
    );
        in_block = (addr[`DAQ_ADDR_BITS-1:`DAQ_BLOCK_BITS] == base);
    endfunction : in_block

    daq_pkg::state_s s_q;
    daq_pkg::state_s s_d;
    logic hit;
    logic rd;
    logic wr;
    logic [3:0] off;
    logic is_timer;
    logic trig;
    logic ext_edge;
    logic pacer_mode;

    assign hit = in_block(i_addr, i_base);
    assign rd = i_io_read & hit;
    assign wr = i_io_write & hit;
    assign off = i_addr[`DAQ_BLOCK_BITS-1:0];
    assign is_timer = (off <= `DAQ_OFF_TIMER_CTRL);
    assign pacer_mode = (s_q.mode == `DAQ_MODE_PACER_DMA)
        | (s_q.mode == `DAQ_MODE_PACER_INT);
    assign ext_edge = i_external_trigger_input & ~s_q.ext_prev;

    // ------------------------------------------------------------
    // Timer pass-through
    // ------------------------------------------------------------
    assign o_timer_select = hit & is_timer & (i_io_read | i_io_write);
    assign o_timer_addr = off[1:0];
    assign o_timer_write = wr & is_timer;
    assign o_timer_read = rd & is_timer & (off != `DAQ_OFF_TIMER_CTRL);
    assign o_timer_wdata = i_wdata;

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    always_comb begin
        if (i_trigger_source_jumper) begin
            trig = ext_edge & pacer_mode;
        end else begin
            trig = (wr & (off == `DAQ_OFF_SW_TRIGGER)
                & (s_q.mode == `DAQ_MODE_SW_POLL))
                | (i_pacer_tick & pacer_mode);
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.rvalid = rd;
        s_d.conv_start = trig;
        s_d.dma_req = i_conv_done & (s_q.mode == `DAQ_MODE_PACER_DMA);
        s_d.ext_prev = i_external_trigger_input;
        if (trig) begin
            s_d.busy = 1'b1;
        end
        if (i_conv_done) begin
            s_d.busy = 1'b0;
            s_d.result = i_conv_result;
        end
        if (wr) begin
            unique case (off)
                `DAQ_OFF_RESULT_LOW: begin
                    s_d.dac0_stage = i_wdata;
                end
                `DAQ_OFF_RESULT_HIGH: begin
                    s_d.dac0 = {i_wdata[3:0], s_q.dac0_stage};
                end
                `DAQ_OFF_DIN_LOW: begin
                    s_d.dac1_stage = i_wdata;
                end
                `DAQ_OFF_DIN_HIGH: begin
                    s_d.dac1 = {i_wdata[3:0], s_q.dac1_stage};
                end
                `DAQ_OFF_STATUS: begin
                    s_d.int_flag = 1'b0;
                end
                `DAQ_OFF_GAIN: begin
                    s_d.gain = i_wdata[1:0];
                end
                `DAQ_OFF_CHANNEL: begin
                    s_d.chan = i_wdata[3:0];
                end
                `DAQ_OFF_MODE: begin
                    s_d.mode = i_wdata[2:0];
                end
                `DAQ_OFF_DOUT_LOW: begin
                    s_d.dout[7:0] = i_wdata;
                end
                `DAQ_OFF_DOUT_HIGH: begin
                    s_d.dout[15:8] = i_wdata;
                end
                default: begin
                end
            endcase
        end
        if (i_conv_done & (s_q.mode == `DAQ_MODE_PACER_INT)) begin
            s_d.int_flag = 1'b1;
        end
        if (rd) begin
            unique case (off)
                `DAQ_OFF_TIMER_CH0,
                `DAQ_OFF_TIMER_CH1,
                `DAQ_OFF_TIMER_CH2: begin
                    s_d.rdata = i_timer_rdata;
                end
                `DAQ_OFF_RESULT_LOW: begin
                    s_d.rdata = s_q.result[7:0];
                end
                `DAQ_OFF_RESULT_HIGH: begin
                    s_d.rdata = s_q.result[15:8];
                end
                `DAQ_OFF_DIN_LOW: begin
                    s_d.rdata = i_digital_input[7:0];
                end
                `DAQ_OFF_DIN_HIGH: begin
                    s_d.rdata = i_digital_input[15:8];
                end
                `DAQ_OFF_STATUS: begin
                    s_d.rdata = `DAQ_BYTE_ZERO;
                    s_d.rdata[`DAQ_READY_BIT] = s_q.busy;
                end
                default: begin
                    s_d.rdata = `DAQ_RESERVED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rdata = s_q.rdata;
    assign o_rdata_valid = s_q.rvalid;
    assign o_conv_start = s_q.conv_start;
    assign o_irq = s_q.int_flag;
    assign o_dma_request = s_q.dma_req;
    assign o_dac0 = s_q.dac0;
    assign o_dac1 = s_q.dac1;
    assign o_gain_code = s_q.gain;
    assign o_channel = i_input_configuration_jumper
        ? {1'b0, s_q.chan[2:0]} : s_q.chan;
    assign o_mode = s_q.mode;
    assign o_digital_output = s_q.dout;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    property p_no_hit_no_read;
        !hit |=> !o_rdata_valid;
    endproperty
    a_no_hit_no_read: assert property (p_no_hit_no_read)
        else $error("Read answered outside the block.");

    property p_timer_write;
        (wr && off == `DAQ_OFF_TIMER_CTRL) |-> o_timer_write
            && o_timer_addr == 2'h3;
    endproperty
    a_timer_write: assert property (p_timer_write)
        else $error("Timer control write not forwarded.");

    property p_result_high;
        (rd && off == `DAQ_OFF_RESULT_HIGH && !i_conv_done)
            |=> o_rdata == $past(s_q.result[15:8]);
    endproperty
    a_result_high: assert property (p_result_high)
        else $error("Result high byte read wrong.");

    property p_result_capture;
        i_conv_done |=> s_q.result == $past(i_conv_result);
    endproperty
    a_result_capture: assert property (p_result_capture)
        else $error("Conversion result not captured.");

    property p_dac_double;
        (wr && off == `DAQ_OFF_RESULT_LOW) |=> $stable(o_dac0);
    endproperty
    a_dac_double: assert property (p_dac_double)
        else $error("First output moved on a low-byte write.");

    property p_dac_update;
        (wr && off == `DAQ_OFF_DIN_HIGH) |=>
            o_dac1 == {$past(i_wdata[3:0]), $past(s_q.dac1_stage)};
    endproperty
    a_dac_update: assert property (p_dac_update)
        else $error("Second output did not update.");

    property p_irq_set;
        (i_conv_done && o_mode == `DAQ_MODE_PACER_INT) |=> o_irq;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("Interrupt not raised after conversion.");

    property p_irq_clear;
        (wr && off == `DAQ_OFF_STATUS && !i_conv_done) |=> !o_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("Interrupt flag not cleared.");

    property p_ready_bit;
        (rd && off == `DAQ_OFF_STATUS) |=>
            o_rdata[`DAQ_READY_BIT] == $past(s_q.busy);
    endproperty
    a_ready_bit: assert property (p_ready_bit)
        else $error("Ready bit does not show pending state.");

    property p_sw_trigger;
        (wr && off == `DAQ_OFF_SW_TRIGGER && !i_trigger_source_jumper
            && o_mode == `DAQ_MODE_SW_POLL) ##1 !trig
            |-> o_conv_start ##1 !o_conv_start;
    endproperty
    a_sw_trigger: assert property (p_sw_trigger)
        else $error("Software trigger pulse missing.");

    property p_diff_chan;
        i_input_configuration_jumper |-> !o_channel[3];
    endproperty
    a_diff_chan: assert property (p_diff_chan)
        else $error("Differential channel uses bit three.");

    property p_dac0_update;
        (wr && off == `DAQ_OFF_RESULT_HIGH) |=>
            o_dac0 == {$past(i_wdata[3:0]), $past(s_q.dac0_stage)};
    endproperty
    a_dac0_update: assert property (p_dac0_update)
        else $error("First output did not update.");

    property p_din_high;
        (rd && off == `DAQ_OFF_DIN_HIGH) |=>
            o_rdata == $past(i_digital_input[15:8]);
    endproperty
    a_din_high: assert property (p_din_high)
        else $error("Digital input high byte read wrong.");

    property p_gain_write;
        (wr && off == `DAQ_OFF_GAIN) |=>
            o_gain_code == $past(i_wdata[`DAQ_GAIN_BITS-1:0]);
    endproperty
    a_gain_write: assert property (p_gain_write)
        else $error("Gain code not taken from the write.");

    property p_mode_write;
        (wr && off == `DAQ_OFF_MODE) |=>
            o_mode == $past(i_wdata[`DAQ_MODE_BITS-1:0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("Mode field not taken from the write.");

    property p_reserved_read;
        (rd && off >= `DAQ_OFF_GAIN) |=>
            o_rdata == `DAQ_RESERVED_READ;
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("Reserved read returned data.");

    property p_mode_off;
        (o_mode == `DAQ_MODE_OFF) |=> !o_conv_start;
    endproperty
    a_mode_off: assert property (p_mode_off)
        else $error("Conversion started with triggering disabled.");

    c_sw_conv: cover property (o_conv_start ##[1:200] i_conv_done);
    c_irq_cycle: cover property (o_irq ##[1:50] !o_irq);
    c_dac_load: cover property ((wr && off == `DAQ_OFF_RESULT_LOW)
        ##[1:10] (wr && off == `DAQ_OFF_RESULT_HIGH));
    c_dma_pulse: cover property (i_conv_done ##1 o_dma_request);
    c_diff_select: cover property (i_input_configuration_jumper
        && o_channel != 4'h0);

endmodule : daq_board_io_register_interface

`default_nettype wire

// ==== logic/daq_pkg.sv ====
`default_nettype none
`include "daq_regs.svh"

package daq_pkg;

    // ------------------------------------------------------------
    // Complete state of the register interface
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] dac0_stage;
        logic [7:0] dac1_stage;
        logic [`DAQ_DAC_BITS-1:0] dac0;
        logic [`DAQ_DAC_BITS-1:0] dac1;
        logic [`DAQ_GAIN_BITS-1:0] gain;
        logic [`DAQ_CHAN_BITS-1:0] chan;
        logic [`DAQ_MODE_BITS-1:0] mode;
        logic int_flag;
        logic busy;
        logic [`DAQ_RESULT_BITS-1:0] result;
        logic [15:0] dout;
        logic [7:0] rdata;
        logic rvalid;
        logic conv_start;
        logic dma_req;
        logic ext_prev;
    } state_s;

endpackage : daq_pkg

`default_nettype wire

// ==== logic/daq_regs.svh ====
`ifndef DAQ_REGS_SVH
`define DAQ_REGS_SVH

// ----------------------------------------------------------------
// Register offsets within the sixteen-location block
// ----------------------------------------------------------------
`define DAQ_BLOCK_BITS 4
`define DAQ_ADDR_BITS 10
`define DAQ_OFF_TIMER_CH0 4'h0
`define DAQ_OFF_TIMER_CH1 4'h1
`define DAQ_OFF_TIMER_CH2 4'h2
`define DAQ_OFF_TIMER_CTRL 4'h3
`define DAQ_OFF_RESULT_LOW 4'h4
`define DAQ_OFF_RESULT_HIGH 4'h5
`define DAQ_OFF_DIN_LOW 4'h6
`define DAQ_OFF_DIN_HIGH 4'h7
`define DAQ_OFF_STATUS 4'h8
`define DAQ_OFF_GAIN 4'h9
`define DAQ_OFF_CHANNEL 4'hA
`define DAQ_OFF_MODE 4'hB
`define DAQ_OFF_SW_TRIGGER 4'hC
`define DAQ_OFF_DOUT_LOW 4'hD
`define DAQ_OFF_DOUT_HIGH 4'hE

// ----------------------------------------------------------------
// Field layouts, codes and reset values
// ----------------------------------------------------------------
`define DAQ_READY_BIT 5
`define DAQ_DAC_BITS 12
`define DAQ_RESULT_BITS 16
`define DAQ_GAIN_BITS 2
`define DAQ_CHAN_BITS 4
`define DAQ_MODE_BITS 3
`define DAQ_MODE_OFF 3'h0
`define DAQ_MODE_SW_POLL 3'h1
`define DAQ_MODE_PACER_DMA 3'h2
`define DAQ_MODE_PACER_INT 3'h6
`define DAQ_RESERVED_READ 8'h00
`define DAQ_BYTE_ZERO 8'h00
`define DAQ_DEFAULT_BASE 6'h22

`endif

// ==== testbench/host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Host processor driving single-cycle bus strobes.
// ----------------------------------------------------------------
module host_model (
    input wire logic i_clock,
    input wire logic [7:0] i_rdata,
    input wire logic i_rdata_valid,
    output logic [9:0] o_addr,
    output logic o_io_read,
    output logic o_io_write,
    output logic [7:0] o_wdata
);
    initial begin
        o_addr = 10'h3FF;
        o_io_read = 1'b0;
        o_io_write = 1'b0;
        o_wdata = 8'hFF;
    end

    // Idle lines show the inverse of the last value driven.
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #10;
        o_addr = a;
        o_wdata = d;
        o_io_write = 1'b1;
        @(posedge i_clock);
        #10;
        o_io_write = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [9:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge i_clock);
        #10;
        o_addr = a;
        o_io_read = 1'b1;
        @(posedge i_clock);
        #10;
        o_io_read = 1'b0;
        o_addr = ~a;
        d = i_rdata;
        v = i_rdata_valid;
    endtask : rd
endmodule : host_model

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "daq_regs.svh"

// ----------------------------------------------------------------
// Self-checking bench for the register interface.
// ----------------------------------------------------------------
module testbench;
    localparam logic [9:0] B = 10'h220;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [9:0] addr;
    logic rd_s, wr_s, rv, done = 1'b0, tick = 1'b0, ext = 1'b0;
    logic src = 1'b0, diff = 1'b0, cs, irq, dma;
    logic [7:0] wd, rdat, trd = 8'h00, d;
    logic [15:0] res = 16'h0000, din = 16'h0000;
    logic [11:0] dac0, dac1;
    logic [1:0] gain;
    logic [3:0] chan;
    logic [2:0] mode;
    logic tsel, trdo, twr;
    logic [1:0] tadr;
    logic [7:0] twd, twcap = 8'h00;
    logic [4:0] tcap = 5'h00;
    logic [15:0] dout;
    logic [5:0] base = 6'h22;
    logic [2:0] codes [4] = '{`DAQ_MODE_OFF, `DAQ_MODE_SW_POLL,
                              `DAQ_MODE_PACER_DMA, `DAQ_MODE_PACER_INT};
    logic [15:0] vals [3] = '{16'h7FFF, 16'h8000, 16'hFFFF};
    int err_total = 0;
    int cmp_count = 0;

    always #50 clock = ~clock;

    always @(posedge clock) begin
        if (rd_s | wr_s) begin
            tcap <= {tsel, trdo, twr, tadr};
            twcap <= twd;
        end
    end

    host_model h (.i_clock(clock), .i_rdata(rdat), .i_rdata_valid(rv),
        .o_addr(addr), .o_io_read(rd_s), .o_io_write(wr_s), .o_wdata(wd));

    daq_board_io_register_interface dut (.i_clock(clock),
        .i_resetn(resetn), .i_addr(addr), .i_io_read(rd_s),
        .i_io_write(wr_s), .i_wdata(wd), .i_base(base), .o_rdata(rdat),
        .o_rdata_valid(rv), .o_timer_select(tsel), .o_timer_addr(tadr),
        .o_timer_read(trdo), .o_timer_write(twr), .o_timer_wdata(twd),
        .i_timer_rdata(trd), .i_conv_result(res), .i_conv_done(done),
        .i_pacer_tick(tick), .i_external_trigger_input(ext),
        .i_trigger_source_jumper(src), .i_input_configuration_jumper(diff),
        .i_digital_input(din), .o_conv_start(cs), .o_irq(irq),
        .o_dma_request(dma), .o_dac0(dac0), .o_dac1(dac1),
        .o_gain_code(gain), .o_channel(chan), .o_mode(mode),
        .o_digital_output(dout));

    task automatic test_done();
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic cyc();
        @(posedge clock);
        #10;
    endtask : cyc

    task automatic rchk(input string n, input logic [9:0] a,
                        input logic [7:0] e);
        logic v;
        h.rd(a, d, v);
        chk({n, " valid"}, 16'h0001, {15'h0000, v});
        chk(n, {8'h00, e}, {8'h00, d});
    endtask : rchk

    task automatic start_seen();
        for (int i = 0; i < 4 && cs !== 1'b1; i++) cyc();
        chk("conv_start", 16'h0001, {15'h0000, cs});
    endtask : start_seen

    task automatic finish_conv(input logic [15:0] r);
        cyc();
        res = r;
        done = 1'b1;
        cyc();
        done = 1'b0;
    endtask : finish_conv

    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            h.wr(B + 10'hB, {5'h1F, codes[i]});
            chk("mode", {13'h0000, codes[i]}, {13'h0000, mode});
            h.wr(B + 10'h9, 8'hFC | i[7:0]);
            chk("gain", i[15:0], {14'h0000, gain});
        end
        h.wr(B + 10'hA, 8'hFB);
        chk("chan", 16'h000B, {12'h000, chan});
        diff = 1'b1;
        cyc();
        chk("chan diff", 16'h0003, {12'h000, chan});
        diff = 1'b0;
        h.wr(B + 10'hD, 8'h5A);
        h.wr(B + 10'hE, 8'hC3);
        chk("dout", 16'hC35A, dout);
    endtask : t_regs

    task automatic t_dac();
        h.wr(B + 10'h4, 8'h34);
        chk("dac0 staged", 16'h0000, {4'h0, dac0});
        h.wr(B + 10'h5, 8'hF2);
        chk("dac0", 16'h0234, {4'h0, dac0});
        h.wr(B + 10'h6, 8'hCD);
        chk("dac1 staged", 16'h0000, {4'h0, dac1});
        h.wr(B + 10'h7, 8'h0A);
        chk("dac1", 16'h0ACD, {4'h0, dac1});
    endtask : t_dac

    task automatic t_inputs();
        din = 16'hA55A;
        trd = 8'h3C;
        rchk("din low", B + 10'h6, 8'h5A);
        rchk("din high", B + 10'h7, 8'hA5);
        rchk("timer", B + 10'h1, 8'h3C);
        chk("timer read pins", 16'h0019, {11'h000, tcap});
        rchk("timer ctrl read", B + 10'h3, `DAQ_RESERVED_READ);
        chk("timer ctrl read pins", 16'h0013, {11'h000, tcap});
        h.wr(B + 10'h3, 8'h36);
        chk("timer ctrl pins", 16'h0017, {11'h000, tcap});
        chk("timer wdata", 16'h0036, {8'h00, twcap});
    endtask : t_inputs

    task automatic t_poll();
        logic v;
        h.wr(B + 10'hB, 8'h01);
        repeat (1000) cyc();
        for (int i = 0; i < 3; i++) begin
            h.wr(B + 10'hC, 8'h5A);
            start_seen();
            h.rd(B + 10'h8, d, v);
            chk("busy", 16'h0001, {15'h0000, d[5]});
            finish_conv(vals[i]);
            h.rd(B + 10'h8, d, v);
            chk("ready", 16'h0000, {15'h0000, d[5]});
            rchk("res low", B + 10'h4, vals[i][7:0]);
            rchk("res high", B + 10'h5, vals[i][15:8]);
        end
        chk("no irq in poll", 16'h0000, {15'h0000, irq});
        h.wr(B + 10'hB, 8'h00);
        h.wr(B + 10'hC, 8'h00);
        chk("mode0 start", 16'h0000, {15'h0000, cs});
    endtask : t_poll

    task automatic t_irq();
        h.wr(B + 10'hB, 8'h06);
        cyc();
        tick = 1'b1;
        cyc();
        tick = 1'b0;
        start_seen();
        finish_conv(16'h1234);
        chk("irq set", 16'h0001, {15'h0000, irq});
        h.wr(B + 10'h8, 8'hA5);
        chk("irq clear", 16'h0000, {15'h0000, irq});
    endtask : t_irq

    task automatic t_ext();
        src = 1'b1;
        h.wr(B + 10'hB, 8'h02);
        ext = 1'b1;
        start_seen();
        finish_conv(16'h0F0F);
        chk("dma", 16'h0001, {15'h0000, dma});
        ext = 1'b0;
        src = 1'b0;
    endtask : t_ext

    task automatic t_block();
        logic v;
        h.wr(10'h320 | 10'h9, 8'h00);
        chk("foreign write", 16'h0003, {14'h0000, gain});
        h.rd(10'h320 | 10'h8, d, v);
        chk("foreign read", 16'h0000, {15'h0000, v});
        rchk("reserved", B + 10'h9, `DAQ_RESERVED_READ);
        chk("reserved side", 16'h0003, {14'h0000, gain});
        rchk("reserved high", B + 10'hE, `DAQ_RESERVED_READ);
        chk("reserved dout", 16'hC35A, dout);
        base = 6'h32;
        h.wr(10'h320 | 10'h9, 8'h01);
        chk("moved base", 16'h0001, {14'h0000, gain});
        base = 6'h22;
    endtask : t_block

    initial begin
        #300000;
        err_total++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clock);
        #10;
        resetn = 1'b1;
        t_dac();
        t_regs();
        t_inputs();
        t_block();
        t_poll();
        t_irq();
        t_ext();
        test_done();
    end
endmodule : testbench

`default_nettype wire
